// ===== cfg_cmd_params.svh
// constants for the configuration command block: command codes, values, layouts
// assumes inclusion by both ends, the write gate, the assertions and the bench
`ifndef CFG_CMD_PARAMS_SVH
`define CFG_CMD_PARAMS_SVH
// command codes
`define CMD_OPERATION 8'h01
`define CMD_ON_OFF_CONFIG 8'h02
`define CMD_PHASE_SELECT 8'h04
`define CMD_WRITE_GUARD 8'h10
`define CMD_SAVE_CONFIG 8'h15
`define CMD_RELOAD_CONFIG 8'h16
`define CMD_FEATURE_REPORT 8'h19
`define CMD_ALERT_MASK 8'h1b
`define CMD_VOUT_COMMAND 8'h21
// status command codes that own a mask
`define STATUS_VOUT 8'h7a
`define STATUS_IOUT 8'h7b
`define STATUS_INPUT 8'h7c
`define STATUS_TEMP 8'h7d
// phase selection values
`define PHASE_ALL 8'hff
`define PHASE_LAST 8'h03
`define PHASE_RESET 8'hff
// write guard levels
`define GUARD_OPEN 8'h00
`define GUARD_LEVEL_20 8'h20
`define GUARD_LEVEL_40 8'h40
`define GUARD_LEVEL_80 8'h80
`define GUARD_RESET 8'h00
// feature report fields
`define FEAT_PEC 1'h1
`define FEAT_SPEED 2'h2
`define FEAT_ALERT 1'h1
`define FEAT_FORMAT 1'h0
`define FEAT_AVSBUS 1'h0
`define FEAT_RSVD 2'h0
// writable bits of each mask
`define MASK_BITS_VOUT 8'hfc
`define MASK_BITS_IOUT 8'hb0
`define MASK_BITS_INPUT 8'he8
`define MASK_BITS_TEMP 8'hc0
// phase count and nvm copy length in cycles
`define PHASE_COUNT_RESET 3'h4
`define NVM_COPY_CYCLES 16'h0040
`endif

// ===== cfg_cmd_pkg.sv
// types shared by both ends of the configuration command link
// assumes cfg_cmd_params.svh is on the include path
package cfg_cmd_pkg;
    // transaction kinds that the host may issue
    typedef enum logic [2:0] {
        op_send_type,
        op_write_byte_type,
        op_write_word_type,
        op_read_byte_type,
        op_proc_call_type
    } op_kind_type;
endpackage

// ===== cfg_cmd_if.sv
// request and answer wires between the host end and the device end
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface cfg_cmd_if (
    input wire logic sys_clk
);
    logic req_valid;
    cfg_cmd_pkg::op_kind_type req_kind;
    logic [7:0] req_code;
    logic [7:0] req_lo;
    logic [7:0] req_hi;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_error;
    logic busy;
    modport host (
        output req_valid, req_kind, req_code, req_lo, req_hi,
        input req_ready, rsp_valid, rsp_data, rsp_error, busy
    );
    modport device (
        input req_valid, req_kind, req_code, req_lo, req_hi,
        output req_ready, rsp_valid, rsp_data, rsp_error, busy
    );
endinterface

// ===== cfg_write_gate.sv
// decides whether a write is allowed by the guard level and whether data is valid
// assumes purely combinational use inside the device end
`timescale 1ns/1ps
`include "cfg_cmd_params.svh"
module cfg_write_gate (
    input wire logic [7:0] guard,
    input wire logic [7:0] code,
    input wire logic [7:0] data,
    input wire logic [2:0] phase_count,
    output logic allowed,
    output logic data_ok
);
    // -------------------------------------------------------------
    // guard level decode
    // -------------------------------------------------------------
    wire logic always_ok = (code == `CMD_WRITE_GUARD) || (code == `CMD_SAVE_CONFIG);
    wire logic lvl20_ok = always_ok || (code == `CMD_OPERATION)
        || (code == `CMD_ON_OFF_CONFIG) || (code == `CMD_VOUT_COMMAND);
    wire logic lvl40_ok = always_ok || (code == `CMD_OPERATION);
    assign allowed = (guard == `GUARD_OPEN) ? 1'b1 :
                     (guard == `GUARD_LEVEL_20) ? lvl20_ok :
                     (guard == `GUARD_LEVEL_40) ? lvl40_ok :
                     always_ok;
    // -------------------------------------------------------------
    // data checks for phase and guard writes
    // -------------------------------------------------------------
    wire logic phase_ok = (data == `PHASE_ALL)
        || ((data <= `PHASE_LAST) && ({5'h00, phase_count} > data));
    wire logic guard_ok = (data == `GUARD_OPEN) || (data == `GUARD_LEVEL_20)
        || (data == `GUARD_LEVEL_40) || (data == `GUARD_LEVEL_80);
    assign data_ok = (code == `CMD_PHASE_SELECT) ? phase_ok :
                     (code == `CMD_WRITE_GUARD) ? guard_ok : 1'b1;
endmodule

// ===== cfg_device_end.sv
// device end: command decode, phase selection, write guard, nvm copy and masks
// assumes the host end keeps to the transaction forms and waits out busy
`timescale 1ns/1ps
`include "cfg_cmd_params.svh"
module cfg_device_end (
    input wire logic sys_clk,
    input wire logic reset,
    cfg_cmd_if.device link,
    input wire logic [2:0] phase_count,
    input wire logic [7:0] strap_override_select,
    input wire logic [7:0] strap_phase,
    input wire logic [3:0] status_vout,
    input wire logic [3:0] status_iout,
    output logic [7:0] active_phase,
    output logic regulation_off,
    output logic bad_data_flag,
    output logic alert_n
);
    typedef enum logic [1:0] {idle_st, save_st, reload_st} dev_state_type;
    dev_state_type state;
    logic [7:0] phase_select;
    logic [7:0] write_guard_level;
    logic [7:0] mask_mem [0:3];
    logic [7:0] saved_guard;
    logic [7:0] saved_mask [0:3];
    logic [15:0] copy_count;
    logic [2:0] phase_count_sync1;
    logic [2:0] phase_count_sync;
    logic [3:0] vout_sync1;
    logic [3:0] vout_sync;
    logic [3:0] iout_sync1;
    logic [3:0] iout_sync;
    logic [7:0] strap_sel_sync1;
    logic [7:0] strap_sel_sync;
    logic [7:0] strap_phase_sync1;
    logic [7:0] strap_phase_sync;
    logic allowed;
    logic data_ok;
    // -------------------------------------------------------------
    // request decode
    // -------------------------------------------------------------
    wire logic take = link.req_valid && link.req_ready;
    wire logic is_write = (link.req_kind == cfg_cmd_pkg::op_write_byte_type)
        || (link.req_kind == cfg_cmd_pkg::op_write_word_type)
        || (link.req_kind == cfg_cmd_pkg::op_send_type);
    wire logic is_mask = link.req_code == `CMD_ALERT_MASK;
    // entry index counted from the vout status code, so 7a..7d map to 0..3
    wire logic [1:0] mask_idx = link.req_lo[1:0] - 2'h2;
    wire logic mask_known = (link.req_lo >= `STATUS_VOUT) && (link.req_lo <= `STATUS_TEMP);
    wire logic [7:0] mask_bits = (mask_idx == 2'h0) ? `MASK_BITS_VOUT :
                                 (mask_idx == 2'h1) ? `MASK_BITS_IOUT :
                                 (mask_idx == 2'h2) ? `MASK_BITS_INPUT : `MASK_BITS_TEMP;
    wire logic mask_ok = mask_known && (phase_select == `PHASE_ALL);
    wire logic feat_write = is_write && (link.req_code == `CMD_FEATURE_REPORT);
    wire logic bad_write = take && is_write && (feat_write || !data_ok
        || (is_mask && !mask_ok));
    wire logic good_write = take && is_write && allowed && !bad_write;
    wire logic [7:0] feature_report = {`FEAT_PEC, `FEAT_SPEED, `FEAT_ALERT,
        `FEAT_FORMAT, `FEAT_AVSBUS, `FEAT_RSVD};
    wire logic [7:0] read_value = (link.req_code == `CMD_PHASE_SELECT) ? phase_select :
        (link.req_code == `CMD_WRITE_GUARD) ? write_guard_level :
        (link.req_code == `CMD_FEATURE_REPORT) ? feature_report :
        (is_mask && mask_ok) ? mask_mem[mask_idx] : 8'h00;
    wire logic read_bad = (link.req_kind == cfg_cmd_pkg::op_proc_call_type) ? !mask_ok
        : (is_mask || ((link.req_code != `CMD_PHASE_SELECT)
        && (link.req_code != `CMD_WRITE_GUARD) && (link.req_code != `CMD_FEATURE_REPORT)));
    wire logic alert_any = |(vout_sync & ~mask_mem[0][7:4])
        | |(iout_sync & ~{mask_mem[1][7], mask_mem[1][5:4], 1'b1});
    cfg_write_gate gate (
        .guard(write_guard_level),
        .code(link.req_code),
        .data(link.req_lo),
        .phase_count(phase_count_sync),
        .allowed(allowed),
        .data_ok(data_ok)
    );
    // -------------------------------------------------------------
    // synchronisers for pins
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase_count_sync1 <= `PHASE_COUNT_RESET;
            phase_count_sync <= `PHASE_COUNT_RESET;
            vout_sync1 <= 4'h0;
            vout_sync <= 4'h0;
            iout_sync1 <= 4'h0;
            iout_sync <= 4'h0;
            strap_sel_sync1 <= 8'h00;
            strap_sel_sync <= 8'h00;
            strap_phase_sync1 <= 8'h00;
            strap_phase_sync <= 8'h00;
        end else begin
            phase_count_sync1 <= phase_count;
            phase_count_sync <= phase_count_sync1;
            vout_sync1 <= status_vout;
            vout_sync <= vout_sync1;
            iout_sync1 <= status_iout;
            iout_sync <= iout_sync1;
            strap_sel_sync1 <= strap_override_select;
            strap_sel_sync <= strap_sel_sync1;
            strap_phase_sync1 <= strap_phase;
            strap_phase_sync <= strap_phase_sync1;
        end
    end
    // -------------------------------------------------------------
    // sequencer for nvm copies
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= idle_st;
            copy_count <= 16'h0000;
            regulation_off <= 1'b0;
        end else begin
            case (state)
                idle_st: begin
                    copy_count <= `NVM_COPY_CYCLES;
                    if (good_write && link.req_code == `CMD_SAVE_CONFIG) begin
                        state <= save_st;
                    end else if (good_write && link.req_code == `CMD_RELOAD_CONFIG) begin
                        state <= reload_st;
                        regulation_off <= 1'b1;
                    end
                end
                save_st, reload_st: begin
                    copy_count <= copy_count - 16'h0001;
                    if (copy_count == 16'h0001) begin
                        state <= idle_st;
                    end
                end
                default: state <= idle_st;
            endcase
        end
    end
    // -------------------------------------------------------------
    // registers and store
    // -------------------------------------------------------------
    wire logic copy_done = (state != idle_st) && (copy_count == 16'h0001);
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase_select <= `PHASE_RESET;
            write_guard_level <= `GUARD_RESET;
            saved_guard <= `GUARD_RESET;
        end else if (copy_done && state == save_st) begin
            saved_guard <= write_guard_level;
        end else if (copy_done && state == reload_st) begin
            write_guard_level <= saved_guard;
            if (strap_sel_sync[0]) begin
                phase_select <= strap_phase_sync;
            end
        end else if (good_write && link.req_code == `CMD_PHASE_SELECT) begin
            phase_select <= link.req_lo;
        end else if (good_write && link.req_code == `CMD_WRITE_GUARD) begin
            write_guard_level <= link.req_lo;
        end
    end
    // per-status mask entries and their saved copies
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mask
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    mask_mem[gi] <= 8'h00;
                    saved_mask[gi] <= 8'h00;
                end else if (copy_done && state == save_st) begin
                    saved_mask[gi] <= mask_mem[gi];
                end else if (copy_done && state == reload_st) begin
                    mask_mem[gi] <= saved_mask[gi];
                end else if (good_write && is_mask && mask_idx == gi
                        && link.req_kind == cfg_cmd_pkg::op_write_word_type) begin
                    mask_mem[gi] <= link.req_hi & mask_bits;
                end
            end
        end
    endgenerate
    // -------------------------------------------------------------
    // answers and outputs
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            link.rsp_valid <= 1'b0;
            link.rsp_data <= 8'h00;
            link.rsp_error <= 1'b0;
            link.req_ready <= 1'b0;
            link.busy <= 1'b0;
            bad_data_flag <= 1'b0;
            active_phase <= `PHASE_RESET;
            alert_n <= 1'b1;
        end else begin
            link.req_ready <= (state == idle_st) && !take && !link.req_ready;
            link.busy <= state != idle_st;
            link.rsp_valid <= take;
            link.rsp_data <= (take && !is_write) ? read_value : 8'h00;
            link.rsp_error <= take && (is_write ? bad_write : read_bad);
            bad_data_flag <= bad_data_flag | bad_write;
            active_phase <= phase_select;
            alert_n <= !(alert_any || bad_data_flag || bad_write);
        end
    end
endmodule

// ===== cfg_host_end.sv
// host end: turns user requests into link transactions and returns answers
// assumes one request at a time from the user side
`timescale 1ns/1ps
`include "cfg_cmd_params.svh"
module cfg_host_end (
    input wire logic sys_clk,
    input wire logic reset,
    cfg_cmd_if.host link,
    input wire logic user_start,
    input wire logic [2:0] user_kind,
    input wire logic [7:0] user_code,
    input wire logic [7:0] user_lo,
    input wire logic [7:0] user_hi,
    output logic user_done,
    output logic [7:0] user_data,
    output logic user_error
);
    // -------------------------------------------------------------
    // request holding
    // -------------------------------------------------------------
    wire logic link_free = !link.req_valid && !link.busy;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            link.req_valid <= 1'b0;
            link.req_kind <= cfg_cmd_pkg::op_send_type;
            link.req_code <= 8'h00;
            link.req_lo <= 8'h00;
            link.req_hi <= 8'h00;
        end else if (link.req_valid && link.req_ready) begin
            link.req_valid <= 1'b0;
        end else if (user_start && link_free) begin
            link.req_valid <= 1'b1;
            link.req_kind <= cfg_cmd_pkg::op_kind_type'(user_kind);
            link.req_code <= user_code;
            link.req_lo <= user_lo;
            link.req_hi <= user_hi;
        end
    end
    // -------------------------------------------------------------
    // answer capture
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            user_done <= 1'b0;
            user_data <= 8'h00;
            user_error <= 1'b0;
        end else begin
            user_done <= link.rsp_valid;
            if (link.rsp_valid) begin
                user_data <= link.rsp_data;
                user_error <= link.rsp_error;
            end
        end
    end
endmodule

// ===== cfg_link_props.sv
// assertions on the link between the host end and the device end
// assumes the link signals, the clock and the reset as plain inputs
`timescale 1ns/1ps
`include "cfg_cmd_params.svh"
module cfg_link_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire cfg_cmd_pkg::op_kind_type req_kind,
    input wire logic [7:0] req_code,
    input wire logic [7:0] req_lo,
    input wire logic [7:0] req_hi,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_error,
    input wire logic busy
);
    // ----------------------------------------
    // request decode
    // ----------------------------------------
    wire logic take = req_valid && req_ready;
    wire logic wr = take && (req_kind == cfg_cmd_pkg::op_write_byte_type);
    wire logic save = take && (req_kind == cfg_cmd_pkg::op_send_type)
        && (req_code == `CMD_SAVE_CONFIG);
    wire logic feat = take && (req_kind == cfg_cmd_pkg::op_read_byte_type)
        && (req_code == `CMD_FEATURE_REPORT);
    wire logic mask_wr = take && (req_kind == cfg_cmd_pkg::op_write_word_type)
        && (req_code == `CMD_ALERT_MASK);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // link timing and refusals
    // ----------------------------------------
    answer_after_take_a: assert property (take |=> rsp_valid)
        else $error("no answer one cycle after a take");
    answer_needs_take_a: assert property (rsp_valid |-> $past(take))
        else $error("answer without a take");
    busy_blocks_take_a: assert property (busy |-> !req_ready)
        else $error("request taken during a copy");
    save_raises_busy_a: assert property (save |-> ##[1:3] busy)
        else $error("save did not start a copy");
    feature_flags_a: assert property (feat |=> rsp_data[7] && rsp_data[4])
        else $error("feature flags wrong");
    feature_fields_a: assert property (feat |=> rsp_data[6:0] == 7'h50)
        else $error("feature fields wrong");
    feature_write_a: assert property (wr && req_code == `CMD_FEATURE_REPORT |=> rsp_error)
        else $error("feature write not refused");
    phase_range_a: assert property (wr && req_code == `CMD_PHASE_SELECT
        && req_lo > `PHASE_LAST && req_lo != `PHASE_ALL |=> rsp_error)
        else $error("bad phase value accepted");
    guard_value_a: assert property (wr && req_code == `CMD_WRITE_GUARD
        && !(req_lo inside {8'h00, 8'h20, 8'h40, 8'h80}) |=> rsp_error)
        else $error("bad guard value accepted");
    mask_code_a: assert property (mask_wr
        && !(req_lo inside {[8'h7a:8'h7d]}) |=> rsp_error)
        else $error("mask write with bad status code accepted");
    cover property (feat ##1 rsp_valid);
    cover property (save ##[1:3] busy);
    cover property (busy ##1 !busy);
endmodule

// ===== tb_top.sv
// self-checking bench: drives the host end user side, both ends joined by the link
// assumes the design files and the parameter header are compiled first
`timescale 1ns/1ps
`include "cfg_cmd_params.svh"
module tb_top;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic user_start = 1'b0;
    logic [2:0] user_kind = 3'h0;
    logic [7:0] user_code = 8'h00;
    logic [7:0] user_lo = 8'h00;
    logic [7:0] user_hi = 8'h00;
    logic [2:0] phase_count = 3'h4;
    logic [7:0] strap_override_select = 8'h01;
    logic [3:0] status_vout = 4'h0;
    logic user_done, user_error, regulation_off, bad_data_flag, alert_n;
    logic [7:0] user_data, active_phase, rd;
    logic er;
    int num_errors = 0;
    int n_tests = 0;
    // ----------------------------------------
    // clock, link and both ends
    // ----------------------------------------
    always #5 sys_clk = ~sys_clk;
    cfg_cmd_if link (.sys_clk(sys_clk));
    cfg_host_end cfg_host_end_inst (.sys_clk(sys_clk), .reset(reset), .link(link.host),
        .user_start(user_start), .user_kind(user_kind), .user_code(user_code),
        .user_lo(user_lo), .user_hi(user_hi), .user_done(user_done),
        .user_data(user_data), .user_error(user_error));
    cfg_device_end cfg_device_end_inst (.sys_clk(sys_clk), .reset(reset),
        .link(link.device), .phase_count(phase_count),
        .strap_override_select(strap_override_select), .strap_phase(8'h00),
        .status_vout(status_vout), .status_iout(4'h0), .active_phase(active_phase),
        .regulation_off(regulation_off), .bad_data_flag(bad_data_flag), .alert_n(alert_n));
    cfg_link_props cfg_link_props_inst (.sys_clk(sys_clk), .reset(reset),
        .req_valid(link.req_valid), .req_kind(link.req_kind), .req_code(link.req_code),
        .req_lo(link.req_lo), .req_hi(link.req_hi), .req_ready(link.req_ready),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
        .rsp_error(link.rsp_error), .busy(link.busy));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // waits n edges, then steps just past the edge
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // one request through the host end, bounded waits for a free link and done
    task automatic xfer(input cfg_cmd_pkg::op_kind_type kind, input logic [7:0] code,
        input logic [7:0] lo, input logic [7:0] hi);
        int i;
        for (i = 0; i < 300 && link.busy !== 1'b0; i++) idle(1);
        if (i == 300) begin
            num_errors++;
            conclude();
        end
        user_kind = kind;
        user_code = code;
        user_lo = lo;
        user_hi = hi;
        user_start = 1'b1;
        idle(1);
        user_start = 1'b0;
        for (i = 0; i < 50 && user_done !== 1'b1; i++) idle(1);
        if (i == 50) begin
            num_errors++;
            conclude();
        end
        rd = user_data;
        er = user_error;
        idle(1);
    endtask
    task automatic wb(input logic [7:0] code, input logic [7:0] lo);
        xfer(cfg_cmd_pkg::op_write_byte_type, code, lo, 8'h00);
    endtask
    task automatic rb(input logic [7:0] code);
        xfer(cfg_cmd_pkg::op_read_byte_type, code, 8'h00, 8'h00);
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        logic [7:0] lvl [3] = '{`GUARD_LEVEL_20, `GUARD_LEVEL_40, `GUARD_LEVEL_80};
        idle(12);
        reset = 1'b0;
        idle(2);
        rb(`CMD_PHASE_SELECT);
        chk("phase reset", rd, `PHASE_RESET);
        rb(`CMD_FEATURE_REPORT);
        chk("feature", rd, 8'hd0);
        $display("reset values done");
        // mask write, read back and its effect on the alert pin
        xfer(cfg_cmd_pkg::op_write_word_type, `CMD_ALERT_MASK, `STATUS_VOUT, 8'hff);
        xfer(cfg_cmd_pkg::op_proc_call_type, `CMD_ALERT_MASK, `STATUS_VOUT, 8'h00);
        chk("mask vout", rd, `MASK_BITS_VOUT);
        xfer(cfg_cmd_pkg::op_write_word_type, `CMD_ALERT_MASK, `STATUS_TEMP, 8'hff);
        xfer(cfg_cmd_pkg::op_proc_call_type, `CMD_ALERT_MASK, `STATUS_TEMP, 8'h00);
        chk("mask temp", rd, `MASK_BITS_TEMP);
        status_vout = 4'hf;
        idle(4);
        chk("alert masked", {7'h0, alert_n}, 8'h01);
        xfer(cfg_cmd_pkg::op_write_word_type, `CMD_ALERT_MASK, `STATUS_VOUT, 8'h00);
        idle(3);
        chk("alert unmasked", {7'h0, alert_n}, 8'h00);
        status_vout = 4'h0;
        // a bad write sets the sticky flag that holds alert low, so it comes last
        xfer(cfg_cmd_pkg::op_write_word_type, `CMD_ALERT_MASK, 8'h7e, 8'hff);
        chk("mask bad code", {7'h0, er}, 8'h01);
        $display("mask done");
        // phase selection and its limits
        phase_count = 3'h2;
        wb(`CMD_PHASE_SELECT, 8'h01);
        chk("active phase", active_phase, 8'h01);
        xfer(cfg_cmd_pkg::op_proc_call_type, `CMD_ALERT_MASK, `STATUS_VOUT, 8'h00);
        chk("mask per phase", {7'h0, er}, 8'h01);
        wb(`CMD_PHASE_SELECT, 8'h03);
        chk("absent phase", {7'h0, er}, 8'h01);
        wb(`CMD_PHASE_SELECT, 8'h04);
        chk("phase range", {7'h0, er}, 8'h01);
        rb(`CMD_PHASE_SELECT);
        chk("phase kept", rd, 8'h01);
        wb(`CMD_PHASE_SELECT, `PHASE_ALL);
        $display("phase done");
        // save, then guard levels, then reload
        xfer(cfg_cmd_pkg::op_write_word_type, `CMD_ALERT_MASK, `STATUS_IOUT, 8'hff);
        xfer(cfg_cmd_pkg::op_send_type, `CMD_SAVE_CONFIG, 8'h00, 8'h00);
        xfer(cfg_cmd_pkg::op_write_word_type, `CMD_ALERT_MASK, `STATUS_IOUT, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wb(`CMD_WRITE_GUARD, lvl[k]);
            wb(`CMD_PHASE_SELECT, 8'h00);
            rb(`CMD_PHASE_SELECT);
            chk("guarded phase", rd, `PHASE_ALL);
            rb(`CMD_WRITE_GUARD);
            chk("guard read", rd, lvl[k]);
        end
        xfer(cfg_cmd_pkg::op_send_type, `CMD_RELOAD_CONFIG, 8'h00, 8'h00);
        chk("guarded reload", {7'h0, regulation_off}, 8'h00);
        wb(`CMD_WRITE_GUARD, `GUARD_OPEN);
        wb(`CMD_WRITE_GUARD, 8'h55);
        chk("bad guard", {7'h0, er}, 8'h01);
        wb(`CMD_PHASE_SELECT, 8'h01);
        chk("open phase", active_phase, 8'h01);
        wb(`CMD_PHASE_SELECT, `PHASE_ALL);
        xfer(cfg_cmd_pkg::op_send_type, `CMD_RELOAD_CONFIG, 8'h00, 8'h00);
        chk("regulation off", {7'h0, regulation_off}, 8'h01);
        // the read waits out the copy, then the strap value stands in phase select
        rb(`CMD_PHASE_SELECT);
        chk("strap phase", rd, 8'h00);
        chk("strap active phase", active_phase, 8'h00);
        // masks answer only with all phases selected
        wb(`CMD_PHASE_SELECT, `PHASE_ALL);
        xfer(cfg_cmd_pkg::op_proc_call_type, `CMD_ALERT_MASK, `STATUS_IOUT, 8'h00);
        chk("reloaded mask", rd, `MASK_BITS_IOUT);
        $display("store and guard done");
        wb(`CMD_FEATURE_REPORT, 8'h00);
        chk("feature write", {7'h0, er}, 8'h01);
        chk("bad data flag", {7'h0, bad_data_flag}, 8'h01);
        $display("feature write done");
        conclude();
    end
endmodule
